/* File: verilog/flash_prot_pkg.sv */
// Purpose: shared constants and carriers for the flash erase and protection front end
// Assumes: 96 KB array of 32-bit words, 1 KB erase units, 2 KB protection regions
// Notes:   word addressed; protection settings arrive as plain input vectors
package flash_prot_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int unsigned ARRAY_BYTES      = 96 * 1024;
  localparam int unsigned WORD_BYTES       = 4;
  localparam int unsigned DATA_W           = 32;
  localparam int unsigned WORDS            = ARRAY_BYTES / WORD_BYTES;
  localparam int unsigned ADDR_W           = $clog2(WORDS);
  localparam int unsigned UNIT_BYTES       = 1024;
  localparam int unsigned UNIT_WORDS       = UNIT_BYTES / WORD_BYTES;
  localparam int unsigned UNIT_OFS_W       = $clog2(UNIT_WORDS);
  localparam int unsigned UNITS            = ARRAY_BYTES / UNIT_BYTES;
  localparam int unsigned UNIT_W           = $clog2(UNITS);
  localparam int unsigned UNITS_PER_REGION = 2;
  localparam int unsigned REGIONS          = UNITS / UNITS_PER_REGION;
  localparam int unsigned REGION_W         = $clog2(REGIONS);

  // ----------------------------------------------------------------
  // values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] ERASED_WORD = 32'hffff_ffff;
  localparam logic [DATA_W-1:0] DENY_WORD   = 32'h0000_0000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    SRC_FETCH = 2'b00,
    SRC_DATA  = 2'b01,
    SRC_DEBUG = 2'b10
  } src_t;

  typedef enum logic [1:0]
  {
    OP_READ  = 2'b00,
    OP_PROG  = 2'b01,
    OP_ERASE = 2'b10
  } op_t;

  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_ERASE = 2'b10
  } state_t;

  typedef struct packed
  {
    src_t              src;
    op_t               op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } req_t;

  typedef struct packed
  {
    logic              denied;
    logic [DATA_W-1:0] rdata;
  } rsp_t;

endpackage : flash_prot_pkg

/* File: verilog/flash_array.sv */
// Purpose: word-wide storage for the flash array, registered read port
// Assumes: one read and one write per clock
// Notes:   stands in for the cell array; erase is done word by word by the sequencer
`timescale 1ns/10ps
module flash_array
  import flash_prot_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [DATA_W-1:0] rd_data
);

  logic [DATA_W-1:0] mem [WORDS];

  always_ff @(posedge clk_sys)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule : flash_array

/* File: verilog/flash_block_erase_and_protection.sv */
// Purpose: flash front end with unit erase, word program and per-region protection
// Assumes: one request outstanding at a time; req_ready gates acceptance
// Notes:   refused requests finish in one cycle with rsp.denied set and no array change
`timescale 1ns/10ps
module flash_block_erase_and_protection
  import flash_prot_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               reset,
  input  wire logic [REGIONS-1:0] region_read_only,
  input  wire logic [REGIONS-1:0] region_exec_only,
  input  wire logic               req_valid,
  output logic                    req_ready,
  input  wire req_t               req,
  output logic                    rsp_valid,
  output rsp_t                    rsp
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic [REGION_W-1:0] region_of(input logic [ADDR_W-1:0] a);
    logic [UNIT_W-1:0] unit;
    unit = a[ADDR_W-1 -: UNIT_W];
    return unit[UNIT_W-1:1];
  endfunction : region_of

  // wl: region locked against change, dl: region closed to data and debugger reads
  function automatic logic refuse(input req_t r, input logic wl, input logic dl);
    logic bad;
    bad = 1'b0;
    if (r.op != OP_READ)
    begin
      bad = wl;
    end
    else if (r.src != SRC_FETCH)
    begin
      bad = dl;
    end
    if (r.addr >= ADDR_W'(WORDS))
    begin
      bad = 1'b1;
    end
    return bad;
  endfunction : refuse

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  state_t                state_reg,  state_next;
  logic [UNIT_W-1:0]     unit_reg,   unit_next;
  logic [UNIT_OFS_W-1:0] ofs_reg,    ofs_next;
  logic                  done_reg,   done_next;
  logic                  deny_reg,   deny_next;
  logic                  rdpend_reg, rdpend_next;
  logic [DATA_W-1:0]     rdata_reg,  rdata_next;

  logic              arr_wr_en;
  logic [ADDR_W-1:0] arr_wr_addr;
  logic [DATA_W-1:0] arr_wr_data;
  logic [ADDR_W-1:0] arr_rd_addr;
  logic [DATA_W-1:0] arr_rd_data;
  logic [REGION_W-1:0] req_region;
  logic              req_bad;

  // ----------------------------------------------------------------
  // per-region locks
  // ----------------------------------------------------------------
  // padded to every index a region field can hold, so an address past the
  // array still picks a defined lock; the range check refuses it in any case
  localparam int unsigned LOCK_SLOTS = 2 ** REGION_W;

  logic [LOCK_SLOTS-1:0] write_lock;
  logic [LOCK_SLOTS-1:0] data_lock;

  for (genvar g = 0; g < LOCK_SLOTS; g++)
  begin : g_lock
    if (g < REGIONS)
    begin : g_region
      // both markings set gives the union of their restrictions
      assign write_lock[g] = region_read_only[g] | region_exec_only[g];
      assign data_lock[g]  = region_exec_only[g];
    end
    else
    begin : g_pad
      assign write_lock[g] = 1'b1;
      assign data_lock[g]  = 1'b1;
    end
  end

  assign req_region = region_of(req.addr);
  assign req_bad    = refuse(req, write_lock[req_region], data_lock[req_region]);
  assign req_ready  = (state_reg == ST_IDLE);

  always_comb
  begin
    state_next  = state_reg;
    unit_next   = unit_reg;
    ofs_next    = ofs_reg;
    done_next   = 1'b0;
    deny_next   = 1'b0;
    rdpend_next = 1'b0;
    // denied and non-read answers carry zeros so protected contents never leak
    rdata_next  = DENY_WORD;
    arr_wr_en   = 1'b0;
    arr_wr_addr = req.addr;
    arr_wr_data = req.wdata;
    arr_rd_addr = req.addr;
    case (state_reg)
      ST_IDLE:
      begin
        if (req_valid)
        begin
          if (req_bad)
          begin
            done_next = 1'b1;
            deny_next = 1'b1;
          end
          else if (req.op == OP_PROG)
          begin
            // the word is stored as given, not combined with the old contents,
            // so software that relies on bits only clearing must erase first
            arr_wr_en   = 1'b1;
            arr_wr_data = req.wdata;
            done_next   = 1'b1;
            state_next  = ST_READ;
          end
          else if (req.op == OP_ERASE)
          begin
            unit_next  = req.addr[ADDR_W-1 -: UNIT_W];
            ofs_next   = '0;
            state_next = ST_ERASE;
          end
          else
          begin
            rdpend_next = 1'b1;
            state_next  = ST_READ;
          end
        end
      end
      ST_READ:
      begin
        // the array registered the word at acceptance; copying it out here keeps
        // the answer on a flip-flop however the request lines move meanwhile
        done_next  = rdpend_reg;
        rdata_next = rdpend_reg ? arr_rd_data : DENY_WORD;
        state_next = ST_IDLE;
      end
      ST_ERASE:
      begin
        // one word per clock; ready stays low until the whole unit is done
        arr_wr_en   = 1'b1;
        arr_wr_addr = {unit_reg, ofs_reg};
        arr_wr_data = ERASED_WORD;
        ofs_next    = ofs_reg + 1'b1;
        if (ofs_reg == UNIT_OFS_W'(UNIT_WORDS - 1))
        begin
          done_next  = 1'b1;
          state_next = ST_IDLE;
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_reg  <= ST_IDLE;
      unit_reg   <= '0;
      ofs_reg    <= '0;
      done_reg   <= 1'b0;
      deny_reg   <= 1'b0;
      rdpend_reg <= 1'b0;
      rdata_reg  <= DENY_WORD;
    end
    else
    begin
      state_reg  <= state_next;
      unit_reg   <= unit_next;
      ofs_reg    <= ofs_next;
      done_reg   <= done_next;
      deny_reg   <= deny_next;
      rdpend_reg <= rdpend_next;
      rdata_reg  <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  flash_array u_array
  (
    .clk_sys (clk_sys),
    .wr_en   (arr_wr_en),
    .wr_addr (arr_wr_addr),
    .wr_data (arr_wr_data),
    .rd_addr (arr_rd_addr),
    .rd_data (arr_rd_data)
  );

  // ----------------------------------------------------------------
  // answer
  // ----------------------------------------------------------------
  assign rsp_valid = done_reg;
  assign rsp       = '{denied: deny_reg, rdata: rdata_reg};

endmodule : flash_block_erase_and_protection

/* File: test/flash_prot_props.sv */
// Purpose: port checks for the flash front end
// Assumes: an erase answer is sampled 257 edges after the accepting edge
// Notes: bound from tb
`timescale 1ns/10ps
module flash_prot_props
  import flash_prot_pkg::*;
(
  input wire logic               clk_sys,
  input wire logic               reset,
  input wire logic [REGIONS-1:0] region_read_only,
  input wire logic [REGIONS-1:0] region_exec_only,
  input wire logic               req_valid,
  input wire logic               req_ready,
  input wire req_t               req,
  input wire logic               rsp_valid,
  input wire rsp_t               rsp
);
  logic go, wr, ok, ro, xo;
  assign go = req_valid && req_ready;
  assign wr = req.op != OP_READ;
  assign ok = req.addr < 15'h6000;
  // guarded by ok so the region index never runs past the flag vectors
  assign ro = ok && region_read_only[req.addr[14:9]];
  assign xo = ok && region_exec_only[req.addr[14:9]];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  ro_write_deny_a: assert property (go && wr && ro |=> rsp_valid && rsp.denied)
    else $error("read-only write not refused");
  xo_write_deny_a: assert property (go && wr && xo |=> rsp_valid && rsp.denied)
    else $error("execute-only write not refused");
  xo_read_deny_a: assert property (go && !wr && xo && req.src != SRC_FETCH
    |=> rsp_valid && rsp.denied) else $error("execute-only read not refused");
  fetch_grant_a: assert property (go && ok && !wr && req.src == SRC_FETCH
    |=> !rsp_valid ##1 (rsp_valid && !rsp.denied)) else $error("fetch refused");
  free_prog_a: assert property (go && ok && req.op == OP_PROG && !ro && !xo
    |=> rsp_valid && !rsp.denied) else $error("free program refused");
  erase_span_a: assert property (go && ok && req.op == OP_ERASE && !ro && !xo
    |=> (!req_ready && !rsp_valid) [*8] ##249 (rsp_valid && !rsp.denied))
    else $error("erase timing wrong");
  range_deny_a: assert property (go && !ok |=> rsp_valid && rsp.denied)
    else $error("out of range not refused");
  deny_zero_a: assert property (rsp_valid && rsp.denied |-> rsp.rdata == DENY_WORD)
    else $error("refused answer leaks data");
endmodule : flash_prot_props

/* File: test/cpu_port_model.sv */
// Purpose: requester for fetch, data and debugger paths
// Assumes: one request at a time
// Notes: idle address and data fields are scrambled so stale values are never trusted
`timescale 1ns/10ps
module cpu_port_model
  import flash_prot_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic req_ready,
  output logic      req_valid,
  output req_t      req
);
  initial
  begin
    req_valid = 1'b0;
    req = '0;
  end

  task automatic send(input src_t s, input op_t o, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d, output bit ok);
    ok = 1'b0;
    @(posedge clk_sys);
    #1;
    req_valid = 1'b1;
    req = '{s, o, a, d};
    // ready follows the state register only, so its value just after an edge
    // is the one the block takes at the next edge
    for (int n = 0; n < 400 && !ok; n++)
    begin
      ok = (req_ready === 1'b1);
      @(posedge clk_sys);
    end
    #1;
    req_valid = 1'b0;
    req.addr = ADDR_W'($urandom);
    req.wdata = $urandom;
  endtask : send
endmodule : cpu_port_model

/* File: test/tb.sv */
// Purpose: self-checking bench for the flash front end
// Assumes: answers come back in request order
// Notes: expected answers come from a word map kept here
`timescale 1ns/10ps
module tb
  import flash_prot_pkg::*;
;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [REGIONS-1:0] ro = '0;
  logic [REGIONS-1:0] xo = '0;
  logic req_valid, req_ready, rsp_valid;
  req_t req;
  rsp_t rsp;
  rsp_t exp_q[$];
  logic [DATA_W-1:0] mem[int];
  int fail_count = 0;
  int checks = 0;
  bit ok;

  always #50 clk_sys = ~clk_sys;

  flash_block_erase_and_protection flash_block_erase_and_protection_i (
    .clk_sys(clk_sys), .reset(reset), .region_read_only(ro), .region_exec_only(xo),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
    .rsp(rsp));
  cpu_port_model cpu_port_model_i (.clk_sys(clk_sys), .req_ready(req_ready),
    .req_valid(req_valid), .req(req));

  task automatic end_sim();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  task automatic op(src_t s, op_t o, int a, logic [DATA_W-1:0] d);
    rsp_t e;
    int r;
    r = a / 512;
    e.denied = a >= WORDS || (o != OP_READ && (ro[r] || xo[r]))
               || (o == OP_READ && s != SRC_FETCH && xo[r]);
    e.rdata = (o == OP_READ && !e.denied) ? mem[a] : DENY_WORD;
    if (!e.denied && o == OP_PROG) mem[a] = d;
    if (!e.denied && o == OP_ERASE)
      for (int i = a / 256 * 256; i < a / 256 * 256 + 256; i++) mem[i] = ERASED_WORD;
    exp_q.push_back(e);
    cpu_port_model_i.send(s, o, a[ADDR_W-1:0], d, ok);
    if (!ok) fail_count++;
    if (!ok) end_sim();
  endtask : op

  task automatic drain(string t);
    for (int n = 0; n < 400 && exp_q.size() > 0; n++) @(posedge clk_sys);
    $display("%s done", t);
    if (exp_q.size() > 0) fail_count++;
    if (exp_q.size() > 0) end_sim();
  endtask : drain

  task automatic mark(logic r, logic x);
    @(posedge clk_sys);
    #1;
    ro[0] = r;
    xo[0] = x;
  endtask : mark

  // --------------------------------------------------------------
  // answer checker
  // --------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    #2;
    if (rsp_valid === 1'b1)
    begin
      checks++;
      if (exp_q.size() == 0 || rsp !== exp_q[0])
      begin
        fail_count++;
        $display("wrong value rsp expected %h seen %h", exp_q[0], rsp);
      end
      if (exp_q.size() > 0) void'(exp_q.pop_front());
    end
  end

  initial
  begin
    int a;
    void'($urandom(11291));
    repeat (3) @(posedge clk_sys);
    #1 reset = 1'b0;
    op(SRC_DATA, OP_PROG, 256, 32'h1234_5678);
    op(SRC_DEBUG, OP_ERASE, 0, 32'h0);
    op(SRC_DATA, OP_READ, 256, 32'h0);
    op(SRC_FETCH, OP_READ, 0, 32'h0);
    op(SRC_DEBUG, OP_READ, 255, 32'h0);
    drain("erase unit");
    op(SRC_DATA, OP_ERASE, 24575, 32'h0);
    op(SRC_DATA, OP_READ, 24575, 32'h0);
    op(SRC_FETCH, OP_READ, 24576, 32'h0);
    drain("array edges");
    for (int m = 1; m < 4; m++)
    begin
      mark(m[0], m[1]);
      op(SRC_DATA, OP_PROG, 10, $urandom);
      op(SRC_FETCH, OP_ERASE, 300, 32'h0);
      op(SRC_DATA, OP_PROG, 600, $urandom);
      for (int s = 0; s < 3; s++) op(src_t'(s), OP_READ, 10, 32'h0);
      drain("protection mode");
    end
    mark(1'b0, 1'b0);
    repeat (8)
    begin
      a = 512 + $urandom_range(1023);
      op(SRC_DEBUG, OP_PROG, a, $urandom);
      op(src_t'($urandom_range(2)), OP_READ, a, 32'h0);
    end
    drain("random unmarked");
    end_sim();
  end
endmodule : tb

bind flash_block_erase_and_protection flash_prot_props flash_prot_props_i (
  .clk_sys(clk_sys), .reset(reset), .region_read_only(region_read_only),
  .region_exec_only(region_exec_only), .req_valid(req_valid), .req_ready(req_ready),
  .req(req), .rsp_valid(rsp_valid), .rsp(rsp));
